// ==== common/cmit_pkg.sv ====
// Shared constants and types of the compare match interval timer
package cmit_pkg;
    // Channel count and widths
    localparam int CMIT_NCH = 2;
    localparam int CMIT_CW = 16;
    localparam int CMIT_PW = 9;

    // Register byte offsets on the bus
    localparam logic [7:0] CMIT_OFS_RUN = 8'h00;
    localparam logic [1:0][7:0] CMIT_OFS_CS = {8'h10, 8'h04};
    localparam logic [1:0][7:0] CMIT_OFS_CNT = {8'h14, 8'h08};
    localparam logic [1:0][7:0] CMIT_OFS_COR = {8'h18, 8'h0c};

    // Values after power-on reset or standby
    localparam logic [15:0] CMIT_CNT_RST = 16'h0000;
    localparam logic [15:0] CMIT_COR_RST = 16'hffff;
    localparam logic [1:0] CMIT_DIV_RST = 2'h0;

    // Control/status field positions
    localparam int CMIT_FLAG_BIT = 7;
    localparam int CMIT_IE_BIT = 6;
    localparam int CMIT_DIV_LSB = 0;

    // Prescaler masks: tick every 8, 32, 128, 512 cycles
    localparam logic [3:0][8:0] CMIT_PRE_MASK = {9'h1ff, 9'h07f, 9'h01f, 9'h007};

    // Divider select codes
    typedef enum logic [1:0] {
        CMIT_DIV8, CMIT_DIV32, CMIT_DIV128, CMIT_DIV512
    } cmit_div_t;

    // Avalon-MM request from the master
    typedef struct packed {
        logic read;
        logic write;
        logic [7:0] address;
        logic [3:0] byteenable;
        logic [31:0] writedata;
    } cmit_bus_req_t;

    // Avalon-MM answer of the slave
    typedef struct packed {
        logic [31:0] readdata;
        logic waitrequest;
    } cmit_bus_rsp_t;

    // Whole state of the timer
    typedef struct packed {
        logic [8:0] pre;
        logic [1:0] run;
        logic [1:0][15:0] cnt;
        logic [1:0][15:0] cor;
        logic [1:0] flag;
        logic [1:0] ie;
        logic [1:0][1:0] div;
        logic [1:0] armed;
        logic [1:0] irq;
        logic [1:0] xreq;
        logic wait_q;
        logic [31:0] rdata;
    } cmit_state_t;
endpackage

// ==== hw/cmit_timer.sv ====
// Two-channel compare match interval timer with an Avalon-MM slave
//
// Behaviour
// - 16-bit counter advances per tick while running
// - Equal to constant: clear counter, set flag
// - Flag with enable set raises interrupt
// - Counting resumes from zero after match
// - Power-on/standby zero counter; manual reset not
// - Power-on/standby set constant all ones
// - Constant is 16-bit read/write period
// - Tick chosen from clock divided 8..512
// - Each channel has own interrupt line
// - Interrupt high exactly while flag and enable
// - Requests also start transfers, fixed priority
// - Match fires on tick after equality
// - Flag cleared by zero write after one-read
// - Transfer completion also clears the flag
// - Match clear beats counter write
// - Word write beats increment
// - Byte write keeps other byte unincremented
// - Two identical independent channels
// - Shared run register, bits 0 and 1
// - Divider codes 00..11 for 8..512, reset 00
// - Flag bit7, enable bit6, divider bits1:0
`timescale 1ns/1ns

module cmit_timer (
    input wire logic clk_sys, // System clock, 10 MHz
    input wire logic rst, // Power-on reset, async, active high
    input wire logic standby_req, // Standby entry, same clock domain
    input wire logic [1:0] xfer_done, // Transfer finished, per channel
    input cmit_pkg::cmit_bus_req_t bus_req, // Avalon-MM request
    output cmit_pkg::cmit_bus_rsp_t bus_rsp, // Avalon-MM answer
    output logic [1:0] match_interrupt, // Interrupt per channel
    output logic [1:0] xfer_req // Transfer start request
);
    import cmit_pkg::*;

    ////////////////////////////////////////////////////////////////
    // State and helper terms

    cmit_state_t state_reg; // All flip-flops
    cmit_state_t state_next; // Their next value

    logic req; // A bus request is present
    logic wr_acc; // Write completes at this edge
    logic rd_acc; // Read completes at this edge
    logic [1:0] tick; // Increment enable per channel
    logic [1:0] match; // Compare match event per channel
    logic [1:0] cs_wr; // Control/status low byte written
    logic [1:0] cs_rd; // Control/status read completes
    logic [1:0] cnt_wr_lo; // Counter low byte written
    logic [1:0] cnt_wr_hi; // Counter high byte written
    logic [1:0] flag_clr; // Software clear of the flag
    logic [1:0] act; // Flag and enable both set

    ////////////////////////////////////////////////////////////////
    // Read multiplexer

    // Unmapped and reserved bits read as zero
    function automatic logic [31:0] rd_word(input cmit_state_t s,
                                            input logic [7:0] a);
        logic [31:0] d;
        d = '0;
        if (a == CMIT_OFS_RUN) begin
            d[1:0] = s.run;
        end
        for (int c = 0; c < CMIT_NCH; c++) begin
            if (a == CMIT_OFS_CS[c]) begin
                d[CMIT_FLAG_BIT] = s.flag[c];
                d[CMIT_IE_BIT] = s.ie[c];
                d[CMIT_DIV_LSB+:2] = s.div[c];
            end
            if (a == CMIT_OFS_CNT[c]) begin
                d[15:0] = s.cnt[c];
            end
            if (a == CMIT_OFS_COR[c]) begin
                d[15:0] = s.cor[c];
            end
        end
        return d;
    endfunction

    ////////////////////////////////////////////////////////////////
    // Next-state logic

    always_comb begin
        state_next = state_reg;
        req = bus_req.read | bus_req.write;
        // The request completes on the edge where wait is low
        wr_acc = bus_req.write & ~state_reg.wait_q;
        rd_acc = bus_req.read & ~state_reg.wait_q;

        // One wait state: drop wait for one cycle per request
        state_next.wait_q = ~(req & state_reg.wait_q);

        // Read data is latched in the wait cycle and held
        if (bus_req.read && state_reg.wait_q) begin
            state_next.rdata = rd_word(state_reg, bus_req.address);
        end

        // Free-running prescaler; channels gate its ticks
        state_next.pre = 9'(state_reg.pre + 9'h001);

        // Shared run register, low byte lane only
        if (wr_acc && bus_req.byteenable[0] &&
            bus_req.address == CMIT_OFS_RUN) begin
            state_next.run = bus_req.writedata[1:0];
        end

        // Channels are copies of one another and share the prescaler and the run register
        // Loop indices are constants, so this unrolls into two copies
        for (int c = 0; c < CMIT_NCH; c++) begin
            // Tick when the selected prescaler bits all roll over
            tick[c] = state_reg.run[c] &&
                ((state_reg.pre & CMIT_PRE_MASK[state_reg.div[c]])
                 == CMIT_PRE_MASK[state_reg.div[c]]);
            // Equality alone does nothing; the next tick fires
            match[c] = tick[c] &&
                (state_reg.cnt[c] == state_reg.cor[c]);

            // Decode of this channel's registers
            cs_wr[c] = wr_acc && bus_req.byteenable[0] &&
                (bus_req.address == CMIT_OFS_CS[c]);
            cs_rd[c] = rd_acc && (bus_req.address == CMIT_OFS_CS[c]);
            cnt_wr_lo[c] = wr_acc && bus_req.byteenable[0] &&
                (bus_req.address == CMIT_OFS_CNT[c]);
            cnt_wr_hi[c] = wr_acc && bus_req.byteenable[1] &&
                (bus_req.address == CMIT_OFS_CNT[c]);

            // Counter: match clear first, then write, then count
            if (match[c]) begin
                // A write in the same edge is lost
                state_next.cnt[c] = CMIT_CNT_RST;
            end else if (cnt_wr_lo[c] || cnt_wr_hi[c]) begin
                // Unwritten byte keeps its old value, no increment
                if (cnt_wr_hi[c]) begin
                    state_next.cnt[c][15:8] =
                        bus_req.writedata[15:8];
                end
                if (cnt_wr_lo[c]) begin
                    state_next.cnt[c][7:0] =
                        bus_req.writedata[7:0];
                end
            end else if (tick[c]) begin
                state_next.cnt[c] =
                    16'(state_reg.cnt[c] + 16'h0001);
            end

            // Period constant, byte lanes honoured
            if (wr_acc && bus_req.address == CMIT_OFS_COR[c]) begin
                if (bus_req.byteenable[0]) begin
                    state_next.cor[c][7:0] =
                        bus_req.writedata[7:0];
                end
                if (bus_req.byteenable[1]) begin
                    state_next.cor[c][15:8] =
                        bus_req.writedata[15:8];
                end
            end

            // Enable and divider bits of control/status
            if (cs_wr[c]) begin
                state_next.ie[c] =
                    bus_req.writedata[CMIT_IE_BIT];
                state_next.div[c] =
                    bus_req.writedata[CMIT_DIV_LSB+:2];
            end

            // Clearing is armed by reading the flag as one
            flag_clr[c] = cs_wr[c] && state_reg.armed[c] &&
                ~bus_req.writedata[CMIT_FLAG_BIT];
            if (cs_rd[c] && state_reg.rdata[CMIT_FLAG_BIT]) begin
                state_next.armed[c] = 1'b1;
            end else if (cs_wr[c]) begin
                // Any control/status write with the low byte lane disarms, so a stale read cannot clear
                state_next.armed[c] = 1'b0;
            end

            // Flag: set beats both clears in the same edge
            if (match[c]) begin
                state_next.flag[c] = 1'b1;
            end else if (flag_clr[c] || xfer_done[c]) begin
                state_next.flag[c] = 1'b0;
            end
        end

        // Standby puts every timer register except the prescaler, the wait state and the read data latch back to reset value
        if (standby_req) begin
            state_next.run = '0;
            state_next.cnt = {CMIT_NCH{CMIT_CNT_RST}};
            state_next.cor = {CMIT_NCH{CMIT_COR_RST}};
            state_next.flag = '0;
            state_next.ie = '0;
            state_next.div = {CMIT_NCH{CMIT_DIV_RST}};
            state_next.armed = '0;
        end

        // Interrupts follow the next flag and enable directly
        act = state_next.flag & state_next.ie;
        state_next.irq = act;
        // Transfer requests: channel 0 outranks channel 1
        state_next.xreq = {act[1] & ~act[0], act[0]};
    end

    ////////////////////////////////////////////////////////////////
    // State register

    // Power-on reset only; manual reset has no input here
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_reg.pre <= '0;
            state_reg.run <= '0;
            state_reg.cnt <= {CMIT_NCH{CMIT_CNT_RST}};
            state_reg.cor <= {CMIT_NCH{CMIT_COR_RST}};
            state_reg.flag <= '0;
            state_reg.ie <= '0;
            state_reg.div <= {CMIT_NCH{CMIT_DIV_RST}};
            state_reg.armed <= '0;
            state_reg.irq <= '0;
            state_reg.xreq <= '0;
            state_reg.wait_q <= 1'b1;
            state_reg.rdata <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Outputs, each straight from a flip-flop

    assign bus_rsp.readdata = state_reg.rdata;
    assign bus_rsp.waitrequest = state_reg.wait_q;
    assign match_interrupt = state_reg.irq;
    assign xfer_req = state_reg.xreq;

    ////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    // Divide-by-8 tick repeats every eighth cycle
    sequence s_tick8;
        state_reg.pre[2:0] == 3'h7;
    endsequence

    sequence s_gap7;
        (state_reg.pre[2:0] != 3'h7) [*7];
    endsequence

    a_prescale_rate: assert property (
        s_tick8 |=> s_gap7 ##1 s_tick8)
        else $error("prescaler tick spacing wrong");

    // Slave answers a fresh request after one wait cycle
    a_bus_one_wait: assert property (
        (req && state_reg.wait_q) |=> !state_reg.wait_q ##1 state_reg.wait_q)
        else $error("waitrequest timing wrong");

    // Channel 0 wins the transfer request when both are active
    a_xfer_prio: assert property (
        xfer_req[1] |-> !xfer_req[0] && !state_reg.flag[0] |
        !state_reg.ie[0])
        else $error("transfer priority violated");

    // Channel 0 asks for a transfer exactly while its interrupt stands
    a_xfer_ch0: assert property (
        xfer_req[0] == match_interrupt[0])
        else $error("channel 0 transfer request wrong");

    // Only the low half carries register data; the rest reads zero
    // A wide read on a 16-bit register must not pick up stale lanes
    a_rdata_upper: assert property (
        !bus_rsp.waitrequest |-> bus_rsp.readdata[31:16] == 16'h0000)
        else $error("read data upper half not zero");

    for (genvar g = 0; g < CMIT_NCH; g++) begin : g_chk
        // Interrupt mirrors flag and enable in the same cycle
        a_irq_level: assert property (
            match_interrupt[g] == (state_reg.flag[g] & state_reg.ie[g]))
            else $error("interrupt level mismatch");

        sequence s_match;
            match[g] && !standby_req;
        endsequence

        // Match clears counter and raises flag one edge later
        a_match_clear: assert property (
            s_match |=> state_reg.cnt[g] == CMIT_CNT_RST &&
            state_reg.flag[g])
            else $error("match did not clear counter");

        // Plain tick counts up by one
        a_count_up: assert property (
            (tick[g] && !match[g] && !cnt_wr_lo[g] && !cnt_wr_hi[g] &&
             !standby_req) |=> state_reg.cnt[g] == 16'($past(state_reg.cnt[g]) + 16'h0001))
            else $error("counter did not advance");

        // Equality without a tick neither moves the counter nor sets the flag
        a_no_early: assert property (
            (state_reg.cnt[g] == state_reg.cor[g] && !tick[g] &&
             !cnt_wr_lo[g] && !cnt_wr_hi[g] && !standby_req)
            |=> $stable(state_reg.cnt[g]) && $stable(state_reg.flag[g]) |
            $fell(state_reg.flag[g]))
            else $error("match fired before tick");

        // Word write wins over increment
        a_word_write: assert property (
            (cnt_wr_lo[g] && cnt_wr_hi[g] && !match[g] && !standby_req)
            |=> state_reg.cnt[g] == $past(bus_req.writedata[15:0]))
            else $error("word write lost");

        // High byte write keeps low byte as before
        a_byte_write: assert property (
            (cnt_wr_hi[g] && !cnt_wr_lo[g] && !match[g] && !standby_req)
            |=> state_reg.cnt[g][7:0] == $past(state_reg.cnt[g][7:0]))
            else $error("byte write disturbed other byte");

        // Transfer completion clears the flag
        a_xfer_clear: assert property (
            (xfer_done[g] && !match[g]) |=> !state_reg.flag[g])
            else $error("flag not cleared by transfer");

        // Flag holds unless cleared by a legal path
        a_flag_hold: assert property (
            (state_reg.flag[g] && !flag_clr[g] && !xfer_done[g] &&
             !standby_req) |=> state_reg.flag[g])
            else $error("flag dropped without clear");

        // Standby restores counter and constant
        a_standby_init: assert property (
            standby_req |=> state_reg.cnt[g] == CMIT_CNT_RST &&
            state_reg.cor[g] == CMIT_COR_RST)
            else $error("standby init failed");

        // A halted channel never ticks, so its counter stands
        a_run_gate: assert property (
            !state_reg.run[g] |-> !tick[g])
            else $error("tick while halted");

        // Zero write after an arming read drops the flag
        a_sw_clear: assert property (
            (flag_clr[g] && !match[g]) |=> !state_reg.flag[g])
            else $error("flag not cleared by software");

        // The flag falls only through one of its clear paths
        a_flag_fall: assert property (
            $fell(state_reg.flag[g]) |->
            $past(flag_clr[g]) || $past(xfer_done[g]) || $past(standby_req))
            else $error("flag fell without clear");

        // A match in the same edge as a clear keeps the flag up
        a_set_wins: assert property (
            (match[g] && (flag_clr[g] || xfer_done[g]) && !standby_req)
            |=> state_reg.flag[g])
            else $error("clear beat a match");

        // Low byte write keeps the high byte as it was
        a_byte_lo: assert property (
            (cnt_wr_lo[g] && !cnt_wr_hi[g] && !match[g] && !standby_req)
            |=> state_reg.cnt[g][15:8] == $past(state_reg.cnt[g][15:8]))
            else $error("byte write disturbed high byte");

        // Both lanes of a constant write land together
        a_cor_write: assert property (
            (wr_acc && bus_req.address == CMIT_OFS_COR[g] &&
             bus_req.byteenable[1:0] == 2'h3 && !standby_req)
            |=> state_reg.cor[g] == $past(bus_req.writedata[15:0]))
            else $error("constant write lost");
    end
endmodule

// ==== dv/cmit_xfer_model.sv ====
// Behavioural transfer controller that answers timer transfer requests
`timescale 1ns/1ns

module cmit_xfer_model #(
    parameter int DELAY = 5 // Completion pulse comes DELAY + 1 cycles after the grant
) (
    input wire logic clk_sys, // System clock
    input wire logic rst, // Power-on reset, active high
    input wire logic enable, // Bench switch, no new grant while low; a transfer in flight still completes
    input wire logic [1:0] xfer_req, // Transfer start request per channel
    output logic [1:0] xfer_done // One-cycle completion pulse per channel
);
    int unsigned wait_cnt; // Cycles spent on the current transfer
    logic busy; // A transfer is in flight
    logic [1:0] grant; // Channel being served, one-hot

    ////////////////////////////////////////////////////////////////////////////
    // Grant, delay, completion pulse, then a short holdoff so a request that
    // has not yet dropped is not taken twice
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            busy <= 1'b0;
            wait_cnt <= 0;
            grant <= 2'h0;
            xfer_done <= 2'h0;
        end else begin
            xfer_done <= 2'h0;
            if (!busy && enable && xfer_req != 2'h0) begin
                busy <= 1'b1;
                wait_cnt <= 0;
                grant <= xfer_req[0] ? 2'h1 : 2'h2;
            end else if (busy) begin
                wait_cnt <= wait_cnt + 1;
                if (wait_cnt == DELAY) begin
                    xfer_done <= grant;
                end
                if (wait_cnt == DELAY + 2) begin
                    busy <= 1'b0;
                end
            end
        end
    end
endmodule

// ==== dv/test_compare_match_interval_timer.sv ====
// Self-checking testbench of the compare match interval timer
`timescale 1ns/1ns

module test_compare_match_interval_timer;
    import cmit_pkg::*;
    logic clk_sys; // 10 MHz system clock
    logic rst; // Power-on reset
    logic standby_req; // Standby entry
    logic [1:0] xfer_done; // From transfer model
    cmit_bus_req_t bus_req; // Bus request driven by the tasks
    cmit_bus_rsp_t bus_rsp; // Bus answer
    logic [1:0] match_interrupt; // Interrupt lines
    logic [1:0] xfer_req; // Transfer requests
    logic xfer_en; // Lets the transfer model answer
    int n_errors; // Mismatch count
    int cmp_count; // Comparison count
    int cyc; // Free cycle counter for period checks
    int t1; // Cycle of a first match
    logic [31:0] rd; // Last read data

    cmit_timer u_cmit_timer (.clk_sys(clk_sys), .rst(rst), .standby_req(standby_req),
        .xfer_done(xfer_done), .bus_req(bus_req), .bus_rsp(bus_rsp),
        .match_interrupt(match_interrupt), .xfer_req(xfer_req));
    cmit_xfer_model u_cmit_xfer_model (.clk_sys(clk_sys), .rst(rst), .enable(xfer_en),
        .xfer_req(xfer_req), .xfer_done(xfer_done));

    ////////////////////////////////////////////////////////////////////////////
    // Clock and cycle count
    always #50 clk_sys = ~clk_sys;
    always @(posedge clk_sys) cyc <= cyc + 1;

    ////////////////////////////////////////////////////////////////////////////
    // Compare and report
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One Avalon transfer; held until waitrequest is seen low at an edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
            input logic [3:0] be);
        int n;
        n = 0;
        @(posedge clk_sys);
        bus_req.read <= !wr;
        bus_req.write <= wr;
        bus_req.address <= a;
        bus_req.writedata <= wd;
        bus_req.byteenable <= be;
        do begin
            @(posedge clk_sys);
            n++;
        end while (bus_rsp.waitrequest !== 1'b0 && n < 50);
        rd = bus_rsp.readdata;
        bus_req.read <= 1'b0;
        bus_req.write <= 1'b0;
        if (n >= 50) begin
            chk("bus answer", 32'h1, 32'h0);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hf);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
        bus(1'b0, a, 32'h0, 4'hf);
        chk(what, exp, rd);
    endtask

    // Bounded wait for an interrupt line; the limit covers the slowest period
    task automatic wait_hi(input int ch);
        int n;
        n = 0;
        while (match_interrupt[ch] !== 1'b1 && n < 3000) begin
            @(posedge clk_sys);
            n++;
        end
        chk("irq raised", 32'h1, {31'h0, match_interrupt[ch]});
    endtask

    // Arm by reading the flag as one, then write zero to it
    task automatic clear(input int ch, input logic [31:0] csv);
        rdc(CMIT_OFS_CS[ch], csv | 32'h80, "flag set");
        wr(CMIT_OFS_CS[ch], csv);
        @(posedge clk_sys);
        chk("irq cleared", 32'h0, {31'h0, match_interrupt[ch]});
    endtask

    // Cycles between two matches must be (constant + 1) ticks
    task automatic measure(input int ch, input logic [31:0] csv, input int exp);
        wr(CMIT_OFS_CS[ch], csv);
        wait_hi(ch);
        t1 = cyc;
        clear(ch, csv);
        wait_hi(ch);
        chk("period", 32'(exp), 32'(cyc - t1));
        clear(ch, csv);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Verdict; one place ends the run
    task automatic close_out();
        $display("compares %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Watchdog, well beyond the few thousand cycles the tests need
    initial begin
        repeat (30000) @(posedge clk_sys);
        n_errors++;
        $display("ERROR watchdog expected finish seen hang");
        close_out();
    end

    ////////////////////////////////////////////////////////////////////////////
    // Test sequence
    initial begin
        clk_sys = 1'b0;
        rst = 1'b1;
        standby_req = 1'b0;
        xfer_en = 1'b0;
        bus_req = '0;
        n_errors = 0;
        cmp_count = 0;
        cyc = 0;
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        rdc(CMIT_OFS_RUN, 32'h0, "run reset");
        for (int ch = 0; ch < 2; ch++) begin
            rdc(CMIT_OFS_CS[ch], 32'h0, "cs reset");
            rdc(CMIT_OFS_CNT[ch], 32'h0, "cnt reset");
            rdc(CMIT_OFS_COR[ch], 32'hffff, "cor reset");
        end
        rdc(8'h1c, 32'h0, "unmapped");
        $display("test reset_values done");
        // Short periods keep the run brief; ch1 walks every divider
        wr(CMIT_OFS_COR[0], 32'h3);
        wr(CMIT_OFS_COR[1], 32'h1);
        // Channel 1 starts only once channel 0 is measured, so no flag is
        // left standing when its enable is first written
        wr(CMIT_OFS_RUN, 32'h1);
        measure(0, 32'h40, 32);
        rdc(CMIT_OFS_CNT[1], 32'h0, "cnt halted");
        wr(CMIT_OFS_RUN, 32'h3);
        for (int d = 0; d < 4; d++) begin
            measure(1, 32'h40 | d, 2 * (8 << (2 * d)));
        end
        // Channel 1 keeps running but may no longer request anything
        wr(CMIT_OFS_CS[1], 32'h0);
        @(posedge clk_sys);
        chk("irq1 masked", 32'h0, {31'h0, match_interrupt[1]});
        $display("test periods done");
        // A zero write with no arming read leaves the flag standing
        wr(CMIT_OFS_CS[0], 32'h40);
        wait_hi(0);
        wr(CMIT_OFS_CS[0], 32'h40);
        @(posedge clk_sys);
        chk("flag kept", 32'h1, {31'h0, match_interrupt[0]});
        clear(0, 32'h40);
        // Disabled interrupt: flag still sets, line stays low
        wr(CMIT_OFS_CS[0], 32'h0);
        repeat (40) @(posedge clk_sys);
        chk("irq masked", 32'h0, {31'h0, match_interrupt[0]});
        clear(0, 32'h0);
        $display("test flag_clear done");
        // Transfer completion clears the flag without software
        xfer_en <= 1'b1;
        wr(CMIT_OFS_CS[0], 32'h40);
        wait_hi(0);
        chk("xfer req", 32'h1, {30'h0, xfer_req});
        repeat (12) @(posedge clk_sys);
        chk("xfer clear", 32'h0, {31'h0, match_interrupt[0]});
        rdc(CMIT_OFS_CS[0], 32'h40, "cs after xfer");
        xfer_en <= 1'b0;
        $display("test transfer done");
        // Standby puts run, counter, constant and control/status back to reset values
        standby_req <= 1'b1;
        repeat (2) @(posedge clk_sys);
        standby_req <= 1'b0;
        rdc(CMIT_OFS_RUN, 32'h0, "run standby");
        rdc(CMIT_OFS_CNT[0], 32'h0, "cnt standby");
        rdc(CMIT_OFS_COR[0], 32'hffff, "cor standby");
        rdc(CMIT_OFS_CS[0], 32'h0, "cs standby");
        $display("test standby done");
        // Word and byte access to a halted counter
        wr(CMIT_OFS_CNT[0], 32'h1234);
        rdc(CMIT_OFS_CNT[0], 32'h1234, "cnt word");
        bus(1'b1, CMIT_OFS_CNT[0], 32'h0000ab00, 4'h2);
        rdc(CMIT_OFS_CNT[0], 32'hab34, "cnt byte");
        wr(CMIT_OFS_COR[1], 32'h5a5a);
        rdc(CMIT_OFS_COR[1], 32'h5a5a, "cor rw");
        wr(8'h1c, 32'hffff);
        rdc(8'h1c, 32'h0, "unmapped write");
        $display("test access done");
        close_out();
    end
endmodule
